//--- adc_regs_pkg.sv
// constants, register map and field layout of the converter control block
// Operation
// - acquisition disable resets 0, blocks both triggers
// - calibration enable resets 0, permits self-calibration
// - read of command register starts calibration
// - one calibration run lasts about 10 ms
// - in-progress flag set during conversion or calibration
// - two-bit range field selects input range
// - range field resets to 10
// - status bit 7 reports board revision
// - plug-and-play variant always reports revision 1
package adc_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_RANGE = 6'h05;
  localparam logic [5:0] IDX_COMMAND = 6'h07;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h08;
  localparam logic [5:0] IDX_EVT_MASK = 6'h09;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RANGE = {IDX_RANGE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = {IDX_COMMAND, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = {IDX_EVT_MASK, 2'h0};
  localparam int WORD_LSB = 2;

  // field positions
  localparam int BIT_CAL_ENABLE = 0;
  localparam int BIT_ACQ_DISABLE = 1;
  localparam int BIT_REVISION = 7;
  localparam int BIT_IN_PROGRESS = 4;
  localparam int RANGE_LSB = 0;
  localparam int RANGE_MSB = 1;
  localparam int EVT_CAL_DONE = 0;
  localparam int EVT_CONV_DONE = 1;
  localparam int EVT_W = 2;

  // range codes
  localparam logic [1:0] RANGE_0_10V = 2'h0;
  localparam logic [1:0] RANGE_5V = 2'h2;
  localparam logic [1:0] RANGE_2P5V = 2'h3;
  localparam logic [1:0] RANGE_RESET = RANGE_5V;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CAL_TIME_MS = 10;
  localparam int CAL_CYCLES = CAL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 10000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 21;
endpackage

//--- adc_run_timer.sv
// countdown timer that times one conversion or calibration run
`timescale 1ns/100ps
module adc_run_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [adc_regs_pkg::TMR_W-1:0] load,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [adc_regs_pkg::TMR_W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_state_s;

  tmr_state_s state_reg;
  tmr_state_s state_next;

  // busy stays high for exactly load enabled cycles
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start && !state_reg.busy) begin
      state_next.cnt = load - adc_regs_pkg::TMR_W'(1);
      state_next.busy = 1'b1;
    end else if (state_reg.busy) begin
      if (state_reg.cnt == '0) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt - adc_regs_pkg::TMR_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
endmodule // adc_run_timer

//--- adc_control_status_regs.sv
// converter command and status registers behind an axi4-lite slave
`timescale 1ns/100ps
module adc_control_status_regs #(
  parameter int unsigned CAL_CYCLES = adc_regs_pkg::CAL_CYCLES,
  parameter bit BOARD_REV_B = 1'b1,
  parameter bit PLUG_AND_PLAY = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [adc_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [adc_regs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic counter_convert_pulse_n,
  input wire logic external_convert_trigger_n,
  output logic adc_convert_start,
  output logic adc_calibrate,
  output logic conversion_in_progress,
  output logic [1:0] input_range_select,
  output logic irq
);
  typedef struct packed {
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic awready;
    logic aw_held;
    logic [adc_regs_pkg::ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_held;
    logic [adc_regs_pkg::REG_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [adc_regs_pkg::REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic acq_disable;
    logic cal_enable;
    logic [1:0] range;
    logic calibrating;
    logic conv_pulse;
    logic [adc_regs_pkg::EVT_W-1:0] evt_status;
    logic [adc_regs_pkg::EVT_W-1:0] evt_mask;
    logic irq;
  } ctl_state_s;

  localparam ctl_state_s STATE_RESET = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    cnt_s1: 1'b1, cnt_s2: 1'b1, cnt_prev: 1'b1,
    ext_s1: 1'b1, ext_s2: 1'b1, ext_prev: 1'b1,
    range: adc_regs_pkg::RANGE_RESET,
    default: '0
  };

  ctl_state_s state_reg;
  ctl_state_s state_next;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_start;
  logic [adc_regs_pkg::TMR_W-1:0] tmr_load;
  logic conv_start;
  logic cal_start;
  logic trig_edge;
  logic wr_fire;
  logic ar_hs;
  logic [adc_regs_pkg::ADDR_W-1:0] wr_addr;
  logic [adc_regs_pkg::REG_W-1:0] status_byte;
  logic [adc_regs_pkg::EVT_W-1:0] evt_clear;
  logic [adc_regs_pkg::EVT_W-1:0] evt_set;

  localparam bit REVISION_FLAG = BOARD_REV_B | PLUG_AND_PLAY;

  // word-aligned register address
  function automatic logic [adc_regs_pkg::ADDR_W-1:0] word_addr(
    input logic [adc_regs_pkg::ADDR_W-1:0] a
  );
    word_addr = {a[adc_regs_pkg::ADDR_W-1:adc_regs_pkg::WORD_LSB], 2'h0};
  endfunction

  always_comb begin
    status_byte = '0;
    status_byte[adc_regs_pkg::BIT_REVISION] = REVISION_FLAG;
    status_byte[adc_regs_pkg::BIT_IN_PROGRESS] = tmr_busy;
  end

  always_comb begin
    state_next = state_reg;
    evt_clear = '0;
    // pins pass two flops before the edge detector looks at them
    state_next.cnt_s1 = counter_convert_pulse_n;
    state_next.cnt_s2 = state_reg.cnt_s1;
    state_next.cnt_prev = state_reg.cnt_s2;
    state_next.ext_s1 = external_convert_trigger_n;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.ext_prev = state_reg.ext_s2;
    trig_edge = (state_reg.cnt_prev & ~state_reg.cnt_s2)
              | (state_reg.ext_prev & ~state_reg.ext_s2);
    // triggers during a run are dropped, not queued
    conv_start = trig_edge && !state_reg.acq_disable
                 && !state_reg.cal_enable && !tmr_busy;

    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata[adc_regs_pkg::REG_W-1:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end
    wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    wr_addr = word_addr(state_reg.aw_addr);
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = adc_regs_pkg::RESP_OKAY;
      case (wr_addr)
        adc_regs_pkg::ADDR_STATUS: begin
          state_next.bresp = adc_regs_pkg::RESP_OKAY;
        end
        adc_regs_pkg::ADDR_RANGE: begin
          if (state_reg.w_lane0) begin
            state_next.range = state_reg.w_data[adc_regs_pkg::RANGE_MSB:adc_regs_pkg::RANGE_LSB];
          end
        end
        adc_regs_pkg::ADDR_COMMAND: begin
          if (state_reg.w_lane0) begin
            state_next.acq_disable = state_reg.w_data[adc_regs_pkg::BIT_ACQ_DISABLE];
            state_next.cal_enable = state_reg.w_data[adc_regs_pkg::BIT_CAL_ENABLE];
          end
        end
        adc_regs_pkg::ADDR_EVT_STATUS: begin
          if (state_reg.w_lane0) begin
            evt_clear = state_reg.w_data[adc_regs_pkg::EVT_W-1:0];
          end
        end
        adc_regs_pkg::ADDR_EVT_MASK: begin
          if (state_reg.w_lane0) begin
            state_next.evt_mask = state_reg.w_data[adc_regs_pkg::EVT_W-1:0];
          end
        end
        default: begin
          state_next.bresp = adc_regs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;

    ar_hs = s_axi_arvalid && state_reg.arready;
    // the discarded read of the command register is the calibration start
    cal_start = ar_hs && (word_addr(s_axi_araddr) == adc_regs_pkg::ADDR_COMMAND)
                && state_reg.cal_enable && !tmr_busy;
    if (ar_hs) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = adc_regs_pkg::RESP_OKAY;
      state_next.rdata = '0;
      case (word_addr(s_axi_araddr))
        adc_regs_pkg::ADDR_STATUS: begin
          state_next.rdata = status_byte;
        end
        adc_regs_pkg::ADDR_RANGE: begin
          state_next.rdata = '0;
        end
        adc_regs_pkg::ADDR_COMMAND: begin
          state_next.rdata[adc_regs_pkg::BIT_ACQ_DISABLE] = state_reg.acq_disable;
          state_next.rdata[adc_regs_pkg::BIT_CAL_ENABLE] = state_reg.cal_enable;
        end
        adc_regs_pkg::ADDR_EVT_STATUS: begin
          state_next.rdata[adc_regs_pkg::EVT_W-1:0] = state_reg.evt_status;
        end
        adc_regs_pkg::ADDR_EVT_MASK: begin
          state_next.rdata[adc_regs_pkg::EVT_W-1:0] = state_reg.evt_mask;
        end
        default: begin
          state_next.rresp = adc_regs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;

    tmr_start = cal_start || conv_start;
    tmr_load = cal_start ? adc_regs_pkg::TMR_W'(CAL_CYCLES)
                         : adc_regs_pkg::TMR_W'(adc_regs_pkg::CONV_CYCLES);
    if (cal_start) begin
      state_next.calibrating = 1'b1;
    end else if (tmr_done) begin
      state_next.calibrating = 1'b0;
    end
    state_next.conv_pulse = conv_start;
    evt_set = '0;
    evt_set[adc_regs_pkg::EVT_CAL_DONE] = tmr_done && state_reg.calibrating;
    evt_set[adc_regs_pkg::EVT_CONV_DONE] = tmr_done && !state_reg.calibrating;
    // a new event wins over a clear in the same cycle
    state_next.evt_status = (state_reg.evt_status & ~evt_clear) | evt_set;
    state_next.irq = |(state_next.evt_status & state_next.evt_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= STATE_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  adc_run_timer u_run_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(tmr_start),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = {{(adc_regs_pkg::DATA_W - adc_regs_pkg::REG_W){1'b0}}, state_reg.rdata};
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign adc_convert_start = state_reg.conv_pulse;
  assign adc_calibrate = state_reg.calibrating;
  assign conversion_in_progress = tmr_busy;
  assign input_range_select = state_reg.range;
  assign irq = state_reg.irq;

  // checks
  int unsigned run_len;
  logic run_cal;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_len <= 0;
      run_cal <= 1'b0;
    end else if (ce) begin
      if (tmr_start && !tmr_busy) begin
        run_len <= 0;
        run_cal <= cal_start;
      end else if (tmr_busy) begin
        run_len <= run_len + 1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_cmd;
    $rose(aresetn) |-> !state_reg.acq_disable && !state_reg.cal_enable;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("command bits not clear after reset");

  property p_disable_blocks;
    ce && state_reg.acq_disable |=> !adc_convert_start;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("trigger passed while disabled");

  property p_trigger_runs;
    ce && trig_edge && !state_reg.acq_disable && !state_reg.cal_enable && !tmr_busy
      |=> adc_convert_start && conversion_in_progress;
  endproperty
  a_trigger_runs: assert property (p_trigger_runs) else $error("enabled trigger did not convert");

  property p_cal_on_read;
    ce && ar_hs && word_addr(s_axi_araddr) == adc_regs_pkg::ADDR_COMMAND
      && state_reg.cal_enable && !tmr_busy |=> conversion_in_progress && adc_calibrate;
  endproperty
  a_cal_on_read: assert property (p_cal_on_read) else $error("command read did not start calibration");

  property p_cal_length;
    $fell(tmr_busy) && run_cal |-> run_len == CAL_CYCLES;
  endproperty
  a_cal_length: assert property (p_cal_length) else $error("calibration run has wrong length");

  property p_status_busy;
    ce && ar_hs && word_addr(s_axi_araddr) == adc_regs_pkg::ADDR_STATUS
      |=> s_axi_rvalid && s_axi_rdata[adc_regs_pkg::BIT_IN_PROGRESS] == $past(tmr_busy);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status busy flag mismatch");

  property p_range_write;
    ce && wr_fire && wr_addr == adc_regs_pkg::ADDR_RANGE && state_reg.w_lane0
      |=> input_range_select == $past(state_reg.w_data[adc_regs_pkg::RANGE_MSB:adc_regs_pkg::RANGE_LSB]);
  endproperty
  a_range_write: assert property (p_range_write) else $error("range write not applied");

  property p_range_reset;
    $rose(aresetn) |-> input_range_select == adc_regs_pkg::RANGE_RESET;
  endproperty
  a_range_reset: assert property (p_range_reset) else $error("range not at reset value");

  property p_status_bits;
    ce && ar_hs && word_addr(s_axi_araddr) == adc_regs_pkg::ADDR_STATUS
      |=> s_axi_rdata[adc_regs_pkg::BIT_REVISION] == REVISION_FLAG && s_axi_rdata[6:5] == 2'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status revision or spare bits wrong");

  property p_status_ro;
    ce && wr_fire && wr_addr == adc_regs_pkg::ADDR_STATUS && !tmr_busy && !tmr_start && !tmr_done
      |=> !conversion_in_progress && $stable(state_reg.evt_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed state");

  property p_irq_level;
    ce |=> irq == |(state_reg.evt_status & state_reg.evt_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

  c_cal_done: cover property ($fell(tmr_busy) && run_cal);
  c_conv_run: cover property (adc_convert_start ##1 conversion_in_progress [*3]);
  c_range_write: cover property (wr_fire && wr_addr == adc_regs_pkg::ADDR_RANGE);
  c_irq: cover property ($rose(irq));
endmodule // adc_control_status_regs

//--- adc_host_model.sv
// axi4-lite master standing in for host software
`timescale 1ns/100ps
module adc_host_model (
  input wire logic aclk,
  output logic [adc_regs_pkg::ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [adc_regs_pkg::DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [adc_regs_pkg::ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [adc_regs_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
        // released lines show the inverse, not a stale copy
        awaddr <= ~a;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // adc_host_model

//--- testbench.sv
// self-checking bench for the converter command and status registers
`timescale 1ns/100ps
module testbench;
  localparam int CAL = 40;
  localparam int LIMIT = 20000;
  localparam logic [31:0] REV = 32'h80;
  localparam logic [7:0] A_ST = adc_regs_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CMD = adc_regs_pkg::ADDR_COMMAND;
  localparam logic [7:0] A_EVT = adc_regs_pkg::ADDR_EVT_STATUS;
  localparam logic [7:0] A_MSK = adc_regs_pkg::ADDR_EVT_MASK;
  localparam int CONV = adc_regs_pkg::CONV_CYCLES;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cnt_n = 1'b1;
  logic ext_n = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic adc_convert_start, adc_calibrate, conversion_in_progress, irq;
  logic [1:0] input_range_select;
  logic [31:0] rd;
  logic [1:0] rs;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int lat;
  int n;

  always #4 aclk = ~aclk;

  adc_control_status_regs #(.CAL_CYCLES(CAL), .BOARD_REV_B(1'b1), .PLUG_AND_PLAY(1'b0)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .counter_convert_pulse_n(cnt_n), .external_convert_trigger_n(ext_n),
    .adc_convert_start(adc_convert_start), .adc_calibrate(adc_calibrate),
    .conversion_in_progress(conversion_in_progress),
    .input_range_select(input_range_select), .irq(irq));

  adc_host_model host_u (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // pulse one trigger pin low; lat is the cycle the start pulse appeared, -1 if never
  task automatic trig(input bit ext);
    lat = -1;
    @(posedge aclk);
    if (ext) ext_n <= 1'b0;
    else cnt_n <= 1'b0;
    for (int i = 1; i <= 8; i++) begin
      @(posedge aclk);
      #1;
      if (adc_convert_start === 1'b1 && lat < 0) lat = i;
    end
    @(posedge aclk);
    ext_n <= 1'b1;
    cnt_n <= 1'b1;
  endtask

  task automatic wait_idle;
    n = 0;
    while (conversion_in_progress !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask

  task automatic t_reset;
    check(input_range_select, 2'h2, "range at reset");
    host_u.read_reg(A_CMD, rd, rs);
    #1;
    check(rd, 32'h0, "command at reset");
    check(conversion_in_progress, 1'b0, "read with enable clear");
    host_u.read_reg(A_ST, rd, rs);
    check(rs, adc_regs_pkg::RESP_OKAY, "status read response");
    // bits 6 and 5 carry nothing and are masked off
    check(rd & 32'hFFFFFF9F, REV, "status at reset");
  endtask

  task automatic t_range;
    logic [1:0] codes [3] = '{2'h0, 2'h3, 2'h2};
    foreach (codes[i]) begin
      host_u.write_reg(adc_regs_pkg::ADDR_RANGE, {30'h0, codes[i]}, rs);
      #1;
      check(input_range_select, codes[i], "range field");
    end
  endtask

  task automatic t_bus_edges;
    host_u.write_reg(A_ST, 32'hFF, rs);
    check(rs, adc_regs_pkg::RESP_OKAY, "status write response");
    host_u.read_reg(A_ST, rd, rs);
    check(rd & 32'hFFFFFF9F, REV, "status after write");
    host_u.read_reg(8'h30, rd, rs);
    check(rs, adc_regs_pkg::RESP_SLVERR, "unmapped read");
    host_u.write_reg(8'h30, 32'h1, rs);
    check(rs, adc_regs_pkg::RESP_SLVERR, "unmapped write");
  endtask

  task automatic t_disable;
    host_u.write_reg(A_CMD, 32'h2, rs);
    trig(1'b0);
    check(lat, -1, "counter pulse while disabled");
    trig(1'b1);
    check(lat, -1, "external trigger while disabled");
    host_u.write_reg(A_CMD, 32'h0, rs);
    trig(1'b1);
    check(lat > 0, 1'b1, "external trigger enabled");
    wait_idle;
    check(n >= CONV - 10 && n <= CONV, 1'b1, "conversion busy span");
    host_u.read_reg(A_EVT, rd, rs);
    check(rd, 32'h2, "conversion done event");
    host_u.write_reg(A_EVT, 32'h2, rs);
  endtask

  task automatic t_cal;
    host_u.write_reg(A_CMD, 32'h1, rs);
    #1;
    check(conversion_in_progress, 1'b0, "write alone idle");
    host_u.read_reg(A_CMD, rd, rs);
    #1;
    check({adc_calibrate, conversion_in_progress}, 2'h3, "calibration running");
    host_u.read_reg(A_ST, rd, rs);
    check(rd & 32'h10, 32'h10, "busy flag in calibration");
    // a frozen run resumes where it stopped, so the span checked below stays the same
    ce <= 1'b0;
    repeat (20) @(posedge aclk);
    check({adc_calibrate, conversion_in_progress}, 2'h3, "run held while frozen");
    ce <= 1'b1;
    wait_idle;
    check(n >= CAL - 10 && n <= CAL, 1'b1, "calibration length");
    host_u.read_reg(A_EVT, rd, rs);
    check(rd, 32'h1, "calibration done event");
    check(adc_calibrate, 1'b0, "calibrate level after run");
    check(irq, 1'b0, "irq masked");
    host_u.write_reg(A_MSK, 32'h1, rs);
    @(posedge aclk);
    #1;
    check(irq, 1'b1, "irq unmasked");
    host_u.write_reg(A_EVT, 32'h1, rs);
    @(posedge aclk);
    #1;
    check(irq, 1'b0, "irq after clear");
    trig(1'b0);
    check(lat, -1, "trigger with enable still set");
    host_u.write_reg(A_CMD, 32'h0, rs);
    trig(1'b0);
    check(lat > 0, 1'b1, "counter pulse after calibration");
    wait_idle;
    host_u.read_reg(A_EVT, rd, rs);
    check(rd, 32'h2, "second conversion event");
    check(irq, 1'b0, "conversion event masked");
    host_u.write_reg(A_EVT, 32'h2, rs);
    host_u.read_reg(A_EVT, rd, rs);
    check(rd, 32'h0, "events cleared");
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("wrong value at %0t ns: run did not finish in time", $time);
      finish_test;
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_range;
    t_bus_edges;
    t_disable;
    t_cal;
    finish_test;
  end
endmodule // testbench
